// *** fiaps_top.sv ***
// Flash in-application programming sequencer with APB register access
`timescale 1ns/1ps
module fiaps_top
  import fiaps_pkg::*;
#(
  parameter int PROG_CYCLES = FIAPS_PROG_CYCLES,
  parameter int UNLOCK_CYCLES = FIAPS_UNLOCK_CYCLES,
  parameter int READ_CYCLES = FIAPS_READ_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] flash_rdata_i,
  output logic [11:0] flash_addr_o,
  output logic [15:0] flash_wdata_o,
  output logic flash_we_o,
  output logic flash_erase_o,
  output logic flash_re_o,
  output logic cpu_stall_o
);
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int UW = $clog2(UNLOCK_CYCLES + 1);

  if (PROG_CYCLES < FIAPS_WORDS_PER_UNIT + 1 || READ_CYCLES < 2 || UNLOCK_CYCLES < 1 ||
      READ_CYCLES > PROG_CYCLES) begin : gen_bad_params
    $error("fiaps_top: unsupported parameter values");
  end

  logic [2:0] operation_mode_field;
  logic program_start_bit;
  logic protect_unlock_bit;
  logic read_enable_bit;
  logic read_start_bit;
  logic erase_write_enabled_flag;
  logic [15:0] flash_addr;
  logic [15:0] data_word [0:3];
  logic [15:0] write_buffer;
  fiaps_state_t state;
  logic [CW-1:0] op_cnt;
  logic [UW-1:0] unlock_cnt;
  logic [11:0] op_addr;

  logic access;
  logic wr_hit;
  logic rd_phase;
  logic busy;
  logic [7:0] ctrl_rd;
  logic op_done;
  logic unlock_expire;
  logic key_ok;
  logic start_prog;
  logic start_read;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == FIAPS_OFF_CTRL) || (a == FIAPS_OFF_ADDR) || (a == FIAPS_OFF_DATA0) ||
                (a == FIAPS_OFF_DATA1) || (a == FIAPS_OFF_DATA2) || (a == FIAPS_OFF_DATA3) ||
                (a == FIAPS_OFF_WBUF);
  endfunction

  // APB: one wait state, answer registered
  assign access = psel_i && penable_i && pready_o;
  assign wr_hit = access && pwrite_i && !pslverr_o;
  assign rd_phase = psel_i && penable_i && !pready_o;
  assign busy = state != FIAPS_IDLE;
  assign ctrl_rd = {erase_write_enabled_flag, read_start_bit, read_enable_bit, protect_unlock_bit,
                    program_start_bit, operation_mode_field};

  assign start_prog = wr_hit && paddr_i == FIAPS_OFF_CTRL && pstrb_i[0] && !busy &&
                      pwdata_i[FIAPS_CTRL_PROG_START] && erase_write_enabled_flag &&
                      (pwdata_i[2:0] == FIAPS_MODE_ERASE || pwdata_i[2:0] == FIAPS_MODE_WRITE);
  assign start_read = wr_hit && paddr_i == FIAPS_OFF_CTRL && pstrb_i[0] && !busy &&
                      pwdata_i[FIAPS_CTRL_READ_START] && pwdata_i[FIAPS_CTRL_READ_EN] &&
                      pwdata_i[2:0] == FIAPS_MODE_READ;
  assign op_done = (state == FIAPS_READ) ? (op_cnt == CW'(READ_CYCLES - 1)) :
                   (busy && op_cnt == CW'(PROG_CYCLES - 1));
  assign unlock_expire = protect_unlock_bit && unlock_cnt == UW'(UNLOCK_CYCLES - 1);
  assign key_ok = protect_unlock_bit && operation_mode_field == FIAPS_MODE_UNLOCK &&
                  data_word[1] == FIAPS_KEY1 && data_word[2] == FIAPS_KEY2 &&
                  data_word[3] == FIAPS_KEY3;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= rd_phase;
      pslverr_o <= rd_phase && !is_mapped(paddr_i);
      if (rd_phase && !pwrite_i) begin
        case (paddr_i)
          FIAPS_OFF_CTRL: prdata_o <= {24'h00_0000, ctrl_rd};
          FIAPS_OFF_ADDR: prdata_o <= {16'h0000, flash_addr};
          FIAPS_OFF_DATA0: prdata_o <= {16'h0000, data_word[0]};
          FIAPS_OFF_DATA1: prdata_o <= {16'h0000, data_word[1]};
          FIAPS_OFF_DATA2: prdata_o <= {16'h0000, data_word[2]};
          FIAPS_OFF_DATA3: prdata_o <= {16'h0000, data_word[3]};
          FIAPS_OFF_WBUF: prdata_o <= {16'h0000, write_buffer};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  // Mode field and read enable; frozen while busy
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      operation_mode_field <= FIAPS_CTRL_RST[2:0];
      read_enable_bit <= 1'b0;
    end else if (wr_hit && paddr_i == FIAPS_OFF_CTRL && pstrb_i[0] && !busy) begin
      operation_mode_field <= pwdata_i[2:0];
      read_enable_bit <= pwdata_i[FIAPS_CTRL_READ_EN];
    end
  end

  // Start bits: set by accepted request, cleared at completion
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      program_start_bit <= 1'b0;
      read_start_bit <= 1'b0;
    end else begin
      if (start_prog) begin
        program_start_bit <= 1'b1;
      end else if (op_done && state != FIAPS_READ) begin
        program_start_bit <= 1'b0;
      end
      if (start_read) begin
        read_start_bit <= 1'b1;
      end else if (op_done && state == FIAPS_READ) begin
        read_start_bit <= 1'b0;
      end
    end
  end

  // Unlock bit, its timer and the enabled flag
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      protect_unlock_bit <= 1'b0;
      unlock_cnt <= '0;
      erase_write_enabled_flag <= 1'b0;
    end else begin
      if (protect_unlock_bit) begin
        unlock_cnt <= unlock_cnt + UW'(1);
      end else begin
        unlock_cnt <= '0;
      end
      if (unlock_expire || key_ok) begin
        protect_unlock_bit <= 1'b0;
      end else if (wr_hit && paddr_i == FIAPS_OFF_CTRL && pstrb_i[0] && !busy &&
                   pwdata_i[FIAPS_CTRL_UNLOCK] && pwdata_i[2:0] == FIAPS_MODE_UNLOCK) begin
        protect_unlock_bit <= 1'b1;
      end
      if (key_ok) begin
        erase_write_enabled_flag <= 1'b1;
      end else if (wr_hit && paddr_i == FIAPS_OFF_CTRL && pstrb_i[0] && !pwdata_i[FIAPS_CTRL_EW_ENABLED]) begin
        erase_write_enabled_flag <= 1'b0;
      end
    end
  end

  // Address pair with auto increment on data word 0 high byte
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      flash_addr <= FIAPS_WORD_RST;
    end else if (wr_hit && paddr_i == FIAPS_OFF_ADDR) begin
      flash_addr <= merge16(flash_addr, pwdata_i, pstrb_i);
    end else if (wr_hit && paddr_i == FIAPS_OFF_DATA0 && pstrb_i[1]) begin
      flash_addr <= flash_addr + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      write_buffer <= FIAPS_WORD_RST;
    end else if (wr_hit && paddr_i == FIAPS_OFF_DATA0 && pstrb_i[1]) begin
      write_buffer <= merge16(data_word[0], pwdata_i, pstrb_i);
    end
  end

  // Data words; word 0 also receives read results
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 4; i++) begin
        data_word[i] <= FIAPS_WORD_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_hit && paddr_i == FIAPS_OFF_DATA0 + 8'(4 * i)) begin
          data_word[i] <= merge16(data_word[i], pwdata_i, pstrb_i);
        end
      end
      if (state == FIAPS_READ && op_done) begin
        data_word[0] <= flash_rdata_i;
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= FIAPS_IDLE;
      op_cnt <= '0;
      op_addr <= 12'h000;
    end else begin
      case (state)
        FIAPS_IDLE: begin
          op_cnt <= '0;
          op_addr <= flash_addr[11:0];
          if (start_read) begin
            state <= FIAPS_READ;
          end else if (start_prog && pwdata_i[2:0] == FIAPS_MODE_ERASE) begin
            state <= FIAPS_ERASE;
          end else if (start_prog) begin
            state <= FIAPS_WRITE;
          end
        end
        FIAPS_ERASE, FIAPS_WRITE, FIAPS_READ: begin
          if (op_done) begin
            state <= FIAPS_IDLE;
            op_cnt <= '0;
          end else begin
            op_cnt <= op_cnt + CW'(1);
          end
        end
        default: begin
          state <= FIAPS_IDLE;
        end
      endcase
    end
  end

  // Flash array strobes
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      flash_addr_o <= 12'h000;
      flash_wdata_o <= 16'h0000;
      flash_we_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_re_o <= 1'b0;
    end else begin
      flash_we_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_re_o <= 1'b0;
      case (state)
        FIAPS_ERASE: begin
          if (op_cnt == '0) begin
            flash_erase_o <= 1'b1;
            flash_addr_o <= {op_addr[11:8], 8'h00};
          end
        end
        FIAPS_WRITE: begin
          if (op_cnt < CW'(FIAPS_WORDS_PER_UNIT)) begin
            flash_we_o <= 1'b1;
            flash_addr_o <= {op_addr[11:2], op_cnt[1:0]};
            flash_wdata_o <= (op_cnt == '0) ? write_buffer : data_word[op_cnt[1:0]];
          end
        end
        FIAPS_READ: begin
          if (op_cnt == '0) begin
            flash_re_o <= 1'b1;
            flash_addr_o <= op_addr;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cpu_stall_o <= 1'b0;
    end else begin
      cpu_stall_o <= (busy && !op_done) || start_prog || start_read;
    end
  end
endmodule

// *** fiaps_pkg.sv ***
// Constants, register map and state encoding of the flash programming sequencer
package fiaps_pkg;
  // Register byte offsets
  localparam logic [7:0] FIAPS_OFF_CTRL = 8'h00;
  localparam logic [7:0] FIAPS_OFF_ADDR = 8'h04;
  localparam logic [7:0] FIAPS_OFF_DATA0 = 8'h08;
  localparam logic [7:0] FIAPS_OFF_DATA1 = 8'h0c;
  localparam logic [7:0] FIAPS_OFF_DATA2 = 8'h10;
  localparam logic [7:0] FIAPS_OFF_DATA3 = 8'h14;
  localparam logic [7:0] FIAPS_OFF_WBUF = 8'h18;

  // Control register field positions
  localparam int FIAPS_CTRL_MODE_LSB = 0;
  localparam int FIAPS_CTRL_PROG_START = 3;
  localparam int FIAPS_CTRL_UNLOCK = 4;
  localparam int FIAPS_CTRL_READ_EN = 5;
  localparam int FIAPS_CTRL_READ_START = 6;
  localparam int FIAPS_CTRL_EW_ENABLED = 7;

  // Operation modes
  localparam logic [2:0] FIAPS_MODE_WRITE = 3'h0;
  localparam logic [2:0] FIAPS_MODE_ERASE = 3'h1;
  localparam logic [2:0] FIAPS_MODE_READ = 3'h3;
  localparam logic [2:0] FIAPS_MODE_UNLOCK = 3'h6;

  // Unlock pattern for data words 1 to 3
  localparam logic [15:0] FIAPS_KEY1 = 16'h0400;
  localparam logic [15:0] FIAPS_KEY2 = 16'h090d;
  localparam logic [15:0] FIAPS_KEY3 = 16'h40c3;

  // Reset values
  localparam logic [7:0] FIAPS_CTRL_RST = 8'h00;
  localparam logic [15:0] FIAPS_WORD_RST = 16'h0000;

  // Timing
  localparam int FIAPS_CLK_PERIOD_NS = 40;
  localparam int FIAPS_PROG_TIME_NS = 2200000;
  localparam int FIAPS_PROG_CYCLES = (FIAPS_PROG_TIME_NS + FIAPS_CLK_PERIOD_NS - 1) / FIAPS_CLK_PERIOD_NS;
  localparam int FIAPS_READ_INSTR = 3;
  localparam int FIAPS_CLK_PER_INSTR = 1;
  localparam int FIAPS_READ_CYCLES = FIAPS_READ_INSTR * FIAPS_CLK_PER_INSTR;
  localparam int FIAPS_UNLOCK_CYCLES = 1024;
  localparam int FIAPS_WORDS_PER_UNIT = 4;

  typedef enum logic [1:0] {
    FIAPS_IDLE = 2'b00,
    FIAPS_ERASE = 2'b01,
    FIAPS_WRITE = 2'b10,
    FIAPS_READ = 2'b11
  } fiaps_state_t;
endpackage

// *** fiaps_sva.sv ***
// Port checker for the flash programming sequencer
`timescale 1ns/1ps
module fiaps_sva #(parameter int PROG_CYCLES = 16, parameter int UNLOCK_CYCLES = 32, parameter int READ_CYCLES = 3) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [11:0] flash_addr_o,
  input wire logic flash_we_o,
  input wire logic flash_erase_o,
  input wire logic flash_re_o,
  input wire logic cpu_stall_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready not given after one wait state");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error flag without ready");
  idle_rdata_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero outside a transfer");
  unit_burst_a: assert property ($rose(flash_we_o) |-> flash_addr_o[1:0] == 2'h0
    ##1 flash_we_o && flash_addr_o[1:0] == 2'h1 ##1 flash_we_o && flash_addr_o[1:0] == 2'h2
    ##1 flash_we_o && flash_addr_o[1:0] == 2'h3 ##1 !flash_we_o)
    else $error("write burst is not four consecutive words");
  block_addr_a: assert property (flash_erase_o |-> flash_addr_o[7:0] == 8'h00 ##1 !flash_erase_o)
    else $error("erase not a single block-aligned pulse");
  erase_stall_a: assert property ($rose(flash_erase_o) |-> cpu_stall_o [*8])
    else $error("stall dropped during erase");
  op_stall_a: assert property (flash_we_o || flash_re_o |-> cpu_stall_o)
    else $error("flash access without stall");
  read_done_a: assert property ($rose(flash_re_o) |-> ##[1:4] !cpu_stall_o)
    else $error("read did not finish in time");
  stall_start_a: assert property ($rose(cpu_stall_o) |=> flash_we_o || flash_erase_o || flash_re_o)
    else $error("stall without flash operation");
endmodule
bind fiaps_top fiaps_sva #(.PROG_CYCLES(PROG_CYCLES), .UNLOCK_CYCLES(UNLOCK_CYCLES), .READ_CYCLES(READ_CYCLES))
  fiaps_sva_inst (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .flash_addr_o(flash_addr_o),
  .flash_we_o(flash_we_o), .flash_erase_o(flash_erase_o), .flash_re_o(flash_re_o), .cpu_stall_o(cpu_stall_o));

// *** fiaps_flash_model.sv ***
// Behavioural model of the flash program array
`timescale 1ns/1ps
module fiaps_flash_model (
  input wire logic clock_i,
  input wire logic [11:0] flash_addr_i,
  input wire logic [15:0] flash_wdata_i,
  input wire logic flash_we_i,
  input wire logic flash_erase_i,
  input wire logic cpu_stall_i,
  output logic [15:0] flash_rdata_o
);
  logic [15:0] mem [0:4095];
  logic [15:0] junk = 16'ha5a5;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 16'hffff;
  end
  always @(posedge clock_i) begin
    junk <= ~junk;
    if (flash_erase_i) begin
      for (int i = 0; i < 256; i++) mem[{flash_addr_i[11:8], 8'(i)}] <= 16'h0000;
    end
    if (flash_we_i) mem[flash_addr_i] <= flash_wdata_i;
  end
  // Data only valid while an operation holds the bus
  assign flash_rdata_o = cpu_stall_i ? mem[flash_addr_i] : junk;
endmodule

// *** flash_iap_sequencer_test.sv ***
// Self-checking bench for the flash programming sequencer
`timescale 1ns/1ps
module flash_iap_sequencer_test;
  import fiaps_pkg::*;
  localparam int PROG = 16;
  localparam int UNLK = 32;
  logic clock_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0, err_o;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] pwdata = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, flash_we_o, flash_erase_o, flash_re_o, cpu_stall_o;
  logic [15:0] flash_rdata_i, flash_wdata_o;
  logic [11:0] flash_addr_o, erase_addr;
  int errors = 0, samples_checked = 0, cycles = 0, erases = 0, writes = 0, t0;
  always #20 clock_i = ~clock_i;
  fiaps_top #(.PROG_CYCLES(PROG), .UNLOCK_CYCLES(UNLK), .READ_CYCLES(3)) fiaps_top_inst (.clock_i(clock_i),
    .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .flash_rdata_i(flash_rdata_i), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
    .flash_we_o(flash_we_o), .flash_erase_o(flash_erase_o), .flash_re_o(flash_re_o), .cpu_stall_o(cpu_stall_o));
  fiaps_flash_model fiaps_flash_model_inst (.clock_i(clock_i), .flash_addr_i(flash_addr_o),
    .flash_wdata_i(flash_wdata_o), .flash_we_i(flash_we_o), .flash_erase_i(flash_erase_o),
    .cpu_stall_i(cpu_stall_o), .flash_rdata_o(flash_rdata_i));
  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (flash_erase_o === 1'b1) begin
      erases++;
      erase_addr = flash_addr_o;
    end
    if (flash_we_o === 1'b1) writes++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) begin
      @(posedge clock_i);
    end
    rd = prdata_o;
    err_o = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wait_clear(input int b);
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    while (rd[b] !== 1'b0) begin
      bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    end
    check({31'h0, rd[b]}, 32'h0);
  endtask
  task automatic t_map();
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'h1c, 32'h0);
    check({rd[30:0], err_o}, 32'h1);
  endtask
  task automatic t_locked();
    bus(1'b1, FIAPS_OFF_CTRL, 32'h9);
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    check(rd, 32'h1);
    check(erases, 32'h0);
  endtask
  task automatic t_timeout();
    bus(1'b1, FIAPS_OFF_DATA1, 32'h1);
    bus(1'b1, FIAPS_OFF_CTRL, 32'h16);
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    check(rd, 32'h16);
    repeat (UNLK) @(posedge clock_i);
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    check(rd, 32'h6);
  endtask
  task automatic t_unlock();
    bus(1'b1, FIAPS_OFF_DATA1, {16'h0, FIAPS_KEY1});
    bus(1'b1, FIAPS_OFF_DATA2, {16'h0, FIAPS_KEY2});
    bus(1'b1, FIAPS_OFF_DATA3, {16'h0, FIAPS_KEY3});
    bus(1'b1, FIAPS_OFF_CTRL, 32'h16);
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    check(rd, 32'h86);
  endtask
  task automatic t_erase();
    bus(1'b1, FIAPS_OFF_ADDR, 32'h345);
    bus(1'b1, FIAPS_OFF_CTRL, 32'h89);
    t0 = cycles;
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    check(rd, 32'h89);
    wait_clear(FIAPS_CTRL_PROG_START);
    check({31'h0, (cycles - t0) inside {[PROG - 2:PROG + 12]}}, 32'h1);
    check({20'h0, erase_addr}, 32'h300);
    check({16'h0, fiaps_flash_model_inst.mem[12'h3ff]}, 32'h0);
    check({16'h0, fiaps_flash_model_inst.mem[12'h2ff]}, 32'hffff);
  endtask
  task automatic t_write();
    bus(1'b1, FIAPS_OFF_ADDR, 32'h126);
    pstrb <= 4'h1;
    bus(1'b1, FIAPS_OFF_DATA0, 32'h0055);
    pstrb <= 4'h3;
    bus(1'b0, FIAPS_OFF_ADDR, 32'h0);
    check(rd, 32'h126);
    bus(1'b1, FIAPS_OFF_DATA0, 32'h1111);
    bus(1'b0, FIAPS_OFF_ADDR, 32'h0);
    check(rd, 32'h127);
    bus(1'b0, FIAPS_OFF_WBUF, 32'h0);
    check(rd, 32'h1111);
    bus(1'b1, FIAPS_OFF_DATA1, 32'h2222);
    bus(1'b1, FIAPS_OFF_DATA2, 32'h3333);
    bus(1'b1, FIAPS_OFF_DATA3, 32'h4444);
    bus(1'b1, FIAPS_OFF_CTRL, 32'h88);
    bus(1'b1, FIAPS_OFF_CTRL, 32'h83);
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    check(rd, 32'h88);
    wait_clear(FIAPS_CTRL_PROG_START);
    check(writes, 32'h4);
    for (int i = 0; i < 4; i++) begin
      check({16'h0, fiaps_flash_model_inst.mem[12'h124 + i]}, 32'h1111 * (i + 1));
    end
  endtask
  task automatic t_read();
    bus(1'b1, FIAPS_OFF_ADDR, 32'h125);
    bus(1'b1, FIAPS_OFF_CTRL, 32'h63);
    wait_clear(FIAPS_CTRL_READ_START);
    bus(1'b0, FIAPS_OFF_DATA0, 32'h0);
    check(rd, 32'h2222);
    bus(1'b1, FIAPS_OFF_CTRL, 32'h9);
    bus(1'b0, FIAPS_OFF_CTRL, 32'h0);
    check(rd, 32'h1);
    check(erases, 32'h1);
    bus(1'b1, FIAPS_OFF_ADDR, 32'h124);
    bus(1'b1, FIAPS_OFF_CTRL, 32'h63);
    wait_clear(FIAPS_CTRL_READ_START);
    bus(1'b0, FIAPS_OFF_DATA0, 32'h0);
    check(rd, 32'h1111);
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    t_map();
    t_locked();
    t_timeout();
    t_unlock();
    t_erase();
    t_write();
    t_read();
    complete_run();
  end
endmodule
